// ### rtl/ipr_map.vh
`ifndef IPR_MAP_VH
`define IPR_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define IPR_OFS_FLAG2       5'h00
`define IPR_OFS_PRIO4       5'h04
`define IPR_OFS_PRIO11      5'h08
`define IPR_OFS_SERVICE     5'h0C
`define IPR_OFS_EVT_STATUS  5'h10
`define IPR_OFS_EVT_MASK    5'h14
`define IPR_OFS_CPU_LEVEL   5'h18
`define IPR_OFS_SRC_PRIO    5'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IPR_FLAG_SPI_ERR    0
`define IPR_FLAG_SPI_EVT    1
`define IPR_FLAG_CAN_RX     2
`define IPR_PRIO_HI_LSB     12
`define IPR_PRIO_MID_LSB    8
`define IPR_PRIO_LO2_LSB    4
`define IPR_PRIO_LO_LSB     0
`define IPR_SVC_LEVEL_LSB   8
`define IPR_SVC_VEC_LSB     0

// ----------------------------------------------------------------
// Widths, reset values and vector numbers
// ----------------------------------------------------------------
`define IPR_PRIO_W          3
`define IPR_LEVEL_W         4
`define IPR_VEC_W           7
`define IPR_NSRC            3
`define IPR_PRIO_RST        3'h4
`define IPR_PRIO_OFF        3'h0
`define IPR_VEC_CAN_RX      7'h40
`define IPR_VEC_SPI_EVT     7'h2A
`define IPR_VEC_SPI_ERR     7'h29

`endif

// ### rtl/ipr_prio_field.v
`timescale 1ns/1ps
// Software priority field; reset value is priority 4
module ipr_prio_field #(
  parameter       W   = 3,
  parameter [W-1:0] RST = 3'h4
) (
  input  wire         clk_in,
  input  wire         rst_n_in,
  input  wire         wr_en_in,
  input  wire [W-1:0] wr_data_in,
  output reg  [W-1:0] prio_out
);
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      prio_out <= RST;
    end else if (wr_en_in) begin
      prio_out <= wr_data_in;
    end
  end
endmodule // ipr_prio_field

// ### rtl/ipr_sticky.v
`timescale 1ns/1ps
// Sticky flags; a set in the same cycle as a clear wins
module ipr_sticky #(
  parameter W = 3
) (
  input  wire         clk_in,
  input  wire         rst_n_in,
  input  wire [W-1:0] set_in,
  input  wire [W-1:0] clr_in,
  output reg  [W-1:0] flag_out
);
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      flag_out <= {W{1'b0}};
    end else begin
      flag_out <= (flag_out & ~clr_in) | set_in;
    end
  end
endmodule // ipr_sticky

// ### rtl/ipr_top.v
`timescale 1ns/1ps
`include "ipr_map.vh"
module ipr_top (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire [4:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  input  wire        can_ch1_rx_req_in,
  input  wire        spi_ch2_event_req_in,
  input  wire        spi_ch2_error_req_in,
  output reg         irq_out,
  output reg         pending_out
);

  // ----------------------------------------------------------------
  // Bus slave handshake
  // ----------------------------------------------------------------
  // One wait cycle: the access completes at the edge where waitrequest is
  // sampled low, so read data is prepared one edge earlier.
  // Back-to-back requests are fine; each one takes two cycles.
  wire        req      = avs_read_in | avs_write_in;
  wire        wr_go    = avs_write_in & ~avs_waitrequest_out;
  wire        rd_go    = avs_read_in & ~avs_waitrequest_out;
  wire [15:0] lane_m   = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  wire        sel_flag = (avs_address_in == `IPR_OFS_FLAG2);
  wire        sel_p4   = (avs_address_in == `IPR_OFS_PRIO4);
  wire        sel_p11  = (avs_address_in == `IPR_OFS_PRIO11);
  wire        sel_est  = (avs_address_in == `IPR_OFS_EVT_STATUS);
  wire        sel_msk  = (avs_address_in == `IPR_OFS_EVT_MASK);
  wire        sel_lvl  = (avs_address_in == `IPR_OFS_CPU_LEVEL);
  wire        sel_sp   = (avs_address_in == `IPR_OFS_SRC_PRIO);
  wire        we_lo    = wr_go & avs_byteenable_in[0];
  wire        we_hi    = wr_go & avs_byteenable_in[1];

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= ~(req & avs_waitrequest_out);
    end
  end

  // ----------------------------------------------------------------
  // Source request flags
  // ----------------------------------------------------------------
  // Software writes 1 to set and 0 to clear; a request in the same cycle wins.
  wire [2:0] req_vec;
  wire [2:0] flag;
  wire [2:0] flag_wmask = (wr_go & sel_flag) ? lane_m[2:0] : 3'h0;
  wire [2:0] flag_wdata = avs_writedata_in[2:0];

  assign req_vec[`IPR_FLAG_CAN_RX]  = can_ch1_rx_req_in;
  assign req_vec[`IPR_FLAG_SPI_EVT] = spi_ch2_event_req_in;
  assign req_vec[`IPR_FLAG_SPI_ERR] = spi_ch2_error_req_in;

  ipr_sticky #(.W(`IPR_NSRC)) u_flags (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .set_in   (req_vec | (flag_wmask & flag_wdata)),
    .clr_in   (flag_wmask & ~flag_wdata),
    .flag_out (flag)
  );

  // ----------------------------------------------------------------
  // Event status with read-to-clear, and mask
  // ----------------------------------------------------------------
  // Read data is captured one edge before the access completes; clearing only
  // the bits that were returned keeps an event that lands in between.
  wire [2:0] evt;
  reg  [2:0] evt_mask;

  ipr_sticky #(.W(`IPR_NSRC)) u_events (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .set_in   (req_vec),
    .clr_in   ((rd_go & sel_est) ? avs_readdata_out[2:0] : 3'h0),
    .flag_out (evt)
  );

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      evt_mask <= 3'h0;
    end else if (we_lo & sel_msk) begin
      evt_mask <= avs_writedata_in[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Priority fields
  // ----------------------------------------------------------------
  // Only the implemented fields are stored, so other bits read zero.
  // Fields in the upper byte need byteenable bit 1, lower-byte fields bit 0.
  wire [2:0] change_notify_priority;
  wire [2:0] i2c_ch1_master_priority;
  wire [2:0] i2c_ch1_slave_priority;
  wire [2:0] timer_six_priority;
  wire [2:0] dma_ch4_priority;
  wire [2:0] out_compare_ch8_priority;
  wire [2:0] can_rx_priority;
  wire [2:0] spi_evt_priority;
  wire [2:0] spi_err_priority;
  reg  [3:0] cpu_level;

  ipr_prio_field #(
    .W   (`IPR_PRIO_W),
    .RST (`IPR_PRIO_RST)
  ) u_cn (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .wr_en_in   (we_hi & sel_p4),
    .wr_data_in (avs_writedata_in[14:12]),
    .prio_out   (change_notify_priority)
  );
  ipr_prio_field #(
    .W   (`IPR_PRIO_W),
    .RST (`IPR_PRIO_RST)
  ) u_mi2c (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .wr_en_in   (we_lo & sel_p4),
    .wr_data_in (avs_writedata_in[6:4]),
    .prio_out   (i2c_ch1_master_priority)
  );
  ipr_prio_field #(
    .W   (`IPR_PRIO_W),
    .RST (`IPR_PRIO_RST)
  ) u_si2c (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .wr_en_in   (we_lo & sel_p4),
    .wr_data_in (avs_writedata_in[2:0]),
    .prio_out   (i2c_ch1_slave_priority)
  );
  ipr_prio_field #(
    .W   (`IPR_PRIO_W),
    .RST (`IPR_PRIO_RST)
  ) u_t6 (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .wr_en_in   (we_hi & sel_p11),
    .wr_data_in (avs_writedata_in[14:12]),
    .prio_out   (timer_six_priority)
  );
  ipr_prio_field #(
    .W   (`IPR_PRIO_W),
    .RST (`IPR_PRIO_RST)
  ) u_dma4 (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .wr_en_in   (we_hi & sel_p11),
    .wr_data_in (avs_writedata_in[10:8]),
    .prio_out   (dma_ch4_priority)
  );
  ipr_prio_field #(
    .W   (`IPR_PRIO_W),
    .RST (`IPR_PRIO_RST)
  ) u_oc8 (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .wr_en_in   (we_lo & sel_p11),
    .wr_data_in (avs_writedata_in[2:0]),
    .prio_out   (out_compare_ch8_priority)
  );
  ipr_prio_field #(
    .W   (`IPR_PRIO_W),
    .RST (`IPR_PRIO_RST)
  ) u_canp (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .wr_en_in   (we_hi & sel_sp),
    .wr_data_in (avs_writedata_in[10:8]),
    .prio_out   (can_rx_priority)
  );
  ipr_prio_field #(
    .W   (`IPR_PRIO_W),
    .RST (`IPR_PRIO_RST)
  ) u_spiep (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .wr_en_in   (we_lo & sel_sp),
    .wr_data_in (avs_writedata_in[6:4]),
    .prio_out   (spi_evt_priority)
  );
  ipr_prio_field #(
    .W   (`IPR_PRIO_W),
    .RST (`IPR_PRIO_RST)
  ) u_spirp (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .wr_en_in   (we_lo & sel_sp),
    .wr_data_in (avs_writedata_in[2:0]),
    .prio_out   (spi_err_priority)
  );

  // Current CPU level, written by software; only a priority above it can pend.
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      cpu_level <= 4'h0;
    end else if (we_lo & sel_lvl) begin
      cpu_level <= avs_writedata_in[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Pending selection
  // ----------------------------------------------------------------
  // A zero priority never beats any level, so the source never pends; irq_out ignores priority.
  // Ties go to the lower flag bit; full arbitration lives elsewhere.
  // The interrupt line follows masked events one cycle late, straight from a flop.
  reg [2:0] win_prio;
  reg [6:0] win_vec;
  reg       win_ok;
  reg [3:0] new_cpu_level;
  reg [6:0] pending_vector_number;

  always @* begin
    win_prio = `IPR_PRIO_OFF;
    win_vec  = 7'h00;
    win_ok   = 1'b0;
    if (flag[`IPR_FLAG_CAN_RX] && ({1'b0, can_rx_priority} > cpu_level)) begin
      win_prio = can_rx_priority;
      win_vec  = `IPR_VEC_CAN_RX;
      win_ok   = 1'b1;
    end
    if (flag[`IPR_FLAG_SPI_EVT] && ({1'b0, spi_evt_priority} > cpu_level)
        && (spi_evt_priority >= win_prio)) begin
      win_prio = spi_evt_priority;
      win_vec  = `IPR_VEC_SPI_EVT;
      win_ok   = 1'b1;
    end
    if (flag[`IPR_FLAG_SPI_ERR] && ({1'b0, spi_err_priority} > cpu_level)
        && (spi_err_priority >= win_prio)) begin
      win_prio = spi_err_priority;
      win_vec  = `IPR_VEC_SPI_ERR;
      win_ok   = 1'b1;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      new_cpu_level         <= 4'h0;
      pending_vector_number <= 7'h00;
      pending_out           <= 1'b0;
      irq_out               <= 1'b0;
    end else begin
      new_cpu_level         <= win_ok ? {1'b0, win_prio} : 4'h0;
      pending_vector_number <= win_vec;
      pending_out           <= win_ok;
      irq_out               <= |(evt & evt_mask);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Lanes 2 and 3 and the upper write half carry nothing; upper read half is zero.
  reg [15:0] rd_mux;

  always @* begin
    case (avs_address_in)
      `IPR_OFS_FLAG2:      rd_mux = {13'h0000, flag};
      `IPR_OFS_PRIO4:      rd_mux = {1'b0, change_notify_priority, 5'h00,
                                     i2c_ch1_master_priority, 1'b0,
                                     i2c_ch1_slave_priority};
      `IPR_OFS_PRIO11:     rd_mux = {1'b0, timer_six_priority, 1'b0, dma_ch4_priority,
                                     5'h00, out_compare_ch8_priority};
      `IPR_OFS_SERVICE:    rd_mux = {4'h0, new_cpu_level, 1'b0,
                                     pending_vector_number};
      `IPR_OFS_EVT_STATUS: rd_mux = {13'h0000, evt};
      `IPR_OFS_EVT_MASK:   rd_mux = {13'h0000, evt_mask};
      `IPR_OFS_CPU_LEVEL:  rd_mux = {12'h000, cpu_level};
      `IPR_OFS_SRC_PRIO:   rd_mux = {5'h00, can_rx_priority, 1'b0, spi_evt_priority,
                                     1'b0, spi_err_priority};
      default:             rd_mux = 16'h0000;
    endcase
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (avs_read_in & avs_waitrequest_out) begin
      avs_readdata_out <= {16'h0000, rd_mux};
    end
  end

endmodule // ipr_top

// ### bench/ipr_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bus and register checks
// ----------------------------------------
module ipr_monitor (
  input wire        clk_in,
  input wire        rst_n_in,
  input wire [4:0]  avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  input wire        irq_out,
  input wire        pending_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire rd_done = avs_read_in && !avs_waitrequest_out;
  wire svc_rd  = rd_done && avs_address_in == 5'h0C;
  wait_one_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("no answer after one wait cycle");
  wait_short_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer held too long");
  wait_cause_a: assert property (!avs_waitrequest_out |-> $past(avs_read_in || avs_write_in))
    else $error("answer without request");
  upper_zero_a: assert property (rd_done |-> avs_readdata_out[31:16] == 16'h0000)
    else $error("upper read half not zero");
  flag_unused_a: assert property (rd_done && avs_address_in == 5'h00 |-> avs_readdata_out[15:3] == 13'h0000)
    else $error("flag spare bits set");
  prio4_unused_a: assert property (rd_done && avs_address_in == 5'h04 |-> (avs_readdata_out & 32'h8F88) == 32'h0)
    else $error("priority 4 spare bits set");
  prio11_unused_a: assert property (rd_done && avs_address_in == 5'h08 |-> (avs_readdata_out & 32'h88F8) == 32'h0)
    else $error("priority 11 spare bits set");
  svc_unused_a: assert property (svc_rd |-> (avs_readdata_out & 32'hF080) == 32'h0)
    else $error("service spare bits set");
  svc_level_a: assert property (svc_rd |-> avs_readdata_out[11:8] <= 4'h7)
    else $error("service level beyond field range");
  svc_idle_a: assert property (svc_rd && avs_readdata_out[11:8] == 4'h0 |-> avs_readdata_out[6:0] == 7'h00)
    else $error("vector shown with no level");
  cover property (svc_rd && pending_out);
  cover property ($rose(irq_out));
  cover property (avs_write_in && !avs_waitrequest_out);
endmodule // ipr_monitor

// ### bench/ipr_partner.sv
`timescale 1ns/1ps
// ----------------------------------------
// Peripheral request sources
// ----------------------------------------
module ipr_partner (
  input  wire       clk_in,
  input  wire [2:0] fire_in,
  output reg  [2:0] req_out
);
  initial req_out = 3'h0;
  // One-cycle strobes, the hardest case for a sticky flag to catch
  always @(posedge clk_in) begin
    req_out <= fire_in;
  end
endmodule // ipr_partner

// ### bench/ipr_top_tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bench top
// ----------------------------------------
module ipr_top_tb_top;
  reg          clk_in = 1'b0;
  reg          rst_n_in = 1'b0;
  reg  [4:0]   avs_address_in = 5'h00;
  reg          avs_read_in = 1'b0;
  reg          avs_write_in = 1'b0;
  reg  [31:0]  avs_writedata_in = 32'h00000000;
  reg  [3:0]   avs_byteenable_in = 4'hF;
  reg  [2:0]   fire = 3'h0;
  wire [31:0]  avs_readdata_out;
  wire         avs_waitrequest_out;
  wire         irq_out;
  wire         pending_out;
  wire [2:0]   req;
  int          fails = 0;
  int          comparisons = 0;
  logic [31:0] q;
  always #12.5 clk_in = ~clk_in;
  ipr_partner src_u (.clk_in(clk_in), .fire_in(fire), .req_out(req));
  ipr_top dut_u (.clk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .can_ch1_rx_req_in(req[2]), .spi_ch2_event_req_in(req[1]),
    .spi_ch2_error_req_in(req[0]), .irq_out, .pending_out);
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Holds the request until waitrequest is sampled low, then idles one cycle
  task bus(input logic w, input logic [4:0] a, input logic [15:0] d, input logic [3:0] be);
    avs_address_in <= a;
    avs_read_in <= !w;
    avs_write_in <= w;
    avs_writedata_in <= {16'h0000, d};
    avs_byteenable_in <= be;
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 16'h0000, 4'hF);
    chk(q, e);
  endtask
  task pulse(input logic [2:0] b);
    fire <= b;
    @(posedge clk_in);
    fire <= 3'h0;
    repeat (4) @(posedge clk_in);
  endtask
  task results;
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task t_reset;
    rd(5'h04, 32'h00004044);
    rd(5'h08, 32'h00004404);
    rd(5'h1C, 32'h00000444);
    wr(5'h0C, 16'hFFFF);
    rd(5'h0C, 32'h00000000);
    rd(5'h1F, 32'h00000000);
    $display("test reset done");
  endtask
  task t_prio;
    wr(5'h04, 16'hFFFF);
    rd(5'h04, 32'h00007077);
    bus(1'b1, 5'h04, 16'h0000, 4'h1);
    rd(5'h04, 32'h00007000);
    wr(5'h08, 16'hFFFF);
    rd(5'h08, 32'h00007707);
    $display("test priority fields done");
  endtask
  task t_flags;
    for (int i = 0; i < 3; i++) begin
      pulse(3'h1 << i);
      rd(5'h00, 32'h00000001 << i);
      wr(5'h00, 16'h0000);
    end
    $display("test flags done");
  endtask
  task t_pend;
    pulse(3'h4);
    rd(5'h0C, 32'h00000440);
    chk(pending_out, 32'h00000001);
    pulse(3'h1);
    rd(5'h0C, 32'h00000429);
    wr(5'h1C, 16'h0744);
    rd(5'h0C, 32'h00000740);
    wr(5'h18, 16'h0007);
    rd(5'h0C, 32'h00000000);
    chk(pending_out, 32'h00000000);
    wr(5'h18, 16'h0000);
    wr(5'h1C, 16'h0000);
    rd(5'h0C, 32'h00000000);
    wr(5'h1C, 16'h0444);
    wr(5'h00, 16'h0000);
    $display("test pending done");
  endtask
  task t_irq;
    bus(1'b0, 5'h10, 16'h0000, 4'hF);
    wr(5'h14, 16'h0002);
    pulse(3'h2);
    chk(irq_out, 32'h00000001);
    rd(5'h10, 32'h00000002);
    repeat (2) @(posedge clk_in);
    chk(irq_out, 32'h00000000);
    pulse(3'h4);
    chk(irq_out, 32'h00000000);
    rd(5'h10, 32'h00000004);
    fork
      pulse(3'h1);
      begin
        @(posedge clk_in);
        rd(5'h10, 32'h00000000);
      end
    join
    rd(5'h10, 32'h00000001);
    $display("test interrupt done");
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset;
    t_prio;
    t_flags;
    t_pend;
    t_irq;
    results;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    results;
  end
endmodule // ipr_top_tb_top
bind ipr_top ipr_monitor mon_u (.clk_in, .rst_n_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .irq_out, .pending_out);
